// >>> rtl/twm_pkg.sv
// Package for the 16-bit timer waveform block: modes, tops, action codes.
// Assumes a single system clock domain and a prescaled count enable.
package twm_pkg;

  // ----------------------------------------------------------------------
  // Widths
  // ----------------------------------------------------------------------
  localparam int CNT_W  = 16;
  localparam int MODE_W = 4;
  localparam int ACT_W  = 2;

  // ----------------------------------------------------------------------
  // Counter extremes and fixed tops
  // ----------------------------------------------------------------------
  localparam logic [15:0] CNT_BOTTOM = 16'h0000;
  localparam logic [15:0] CNT_MAX    = 16'hFFFF;
  localparam logic [15:0] TOP_8BIT   = 16'h00FF;
  localparam logic [15:0] TOP_9BIT   = 16'h01FF;
  localparam logic [15:0] TOP_10BIT  = 16'h03FF;

  // ----------------------------------------------------------------------
  // Waveform mode select codes
  // ----------------------------------------------------------------------
  localparam logic [3:0] MODE_NORMAL    = 4'h0;
  localparam logic [3:0] MODE_CTC_CMPA  = 4'h4;
  localparam logic [3:0] MODE_FAST_8    = 4'h5;
  localparam logic [3:0] MODE_FAST_9    = 4'h6;
  localparam logic [3:0] MODE_FAST_10   = 4'h7;
  localparam logic [3:0] MODE_CTC_CAPT  = 4'hC;
  localparam logic [3:0] MODE_FAST_CAPT = 4'hE;
  localparam logic [3:0] MODE_FAST_CMPA = 4'hF;

  // ----------------------------------------------------------------------
  // Compare output action codes
  // ----------------------------------------------------------------------
  localparam logic [1:0] ACT_NONE   = 2'h0;
  localparam logic [1:0] ACT_TOGGLE = 2'h1;
  localparam logic [1:0] ACT_CLEAR  = 2'h2;
  localparam logic [1:0] ACT_SET    = 2'h3;

  // Counting sequence kinds
  typedef enum logic [1:0] {
    TWM_SEQ_NORMAL,
    TWM_SEQ_CTC,
    TWM_SEQ_FAST,
    TWM_SEQ_OTHER
  } twm_seq_e;

endpackage

// >>> rtl/twm_mode_dec.sv
// Mode decoder: sequence kind, top value and which register defines top.
// Purely combinational; fed from the same clock domain as the timer core.
`timescale 1ns/1ps
module twm_mode_dec (
  // Configuration
  input  wire logic [3:0]       waveform_mode_select,
  input  wire logic [15:0]      compare_a_active,
  input  wire logic [15:0]      capture_value,
  // Decoded results
  output twm_pkg::twm_seq_e     seq_kind,
  output logic      [15:0]      top_value,
  output logic                  top_is_cmpa,
  output logic                  top_is_capt,
  output logic      [15:0]      fixed_mask
);

  // ----------------------------------------------------------------------
  // Decode
  // ----------------------------------------------------------------------
  // Unlisted codes (dual-slope modes) fall to OTHER: counter holds
  always_comb begin
    seq_kind    = twm_pkg::TWM_SEQ_OTHER;
    top_value   = twm_pkg::CNT_MAX;
    top_is_cmpa = 1'b0;
    top_is_capt = 1'b0;
    fixed_mask  = twm_pkg::CNT_MAX;
    unique case (waveform_mode_select)
      twm_pkg::MODE_NORMAL: begin
        seq_kind = twm_pkg::TWM_SEQ_NORMAL;
      end
      twm_pkg::MODE_CTC_CMPA: begin
        seq_kind    = twm_pkg::TWM_SEQ_CTC;
        top_value   = compare_a_active;
        top_is_cmpa = 1'b1;
      end
      twm_pkg::MODE_CTC_CAPT: begin
        seq_kind    = twm_pkg::TWM_SEQ_CTC;
        top_value   = capture_value;
        top_is_capt = 1'b1;
      end
      twm_pkg::MODE_FAST_8: begin
        seq_kind   = twm_pkg::TWM_SEQ_FAST;
        top_value  = twm_pkg::TOP_8BIT;
        fixed_mask = twm_pkg::TOP_8BIT;
      end
      twm_pkg::MODE_FAST_9: begin
        seq_kind   = twm_pkg::TWM_SEQ_FAST;
        top_value  = twm_pkg::TOP_9BIT;
        fixed_mask = twm_pkg::TOP_9BIT;
      end
      twm_pkg::MODE_FAST_10: begin
        seq_kind   = twm_pkg::TWM_SEQ_FAST;
        top_value  = twm_pkg::TOP_10BIT;
        fixed_mask = twm_pkg::TOP_10BIT;
      end
      twm_pkg::MODE_FAST_CAPT: begin
        seq_kind    = twm_pkg::TWM_SEQ_FAST;
        top_value   = capture_value;
        top_is_capt = 1'b1;
      end
      twm_pkg::MODE_FAST_CMPA: begin
        seq_kind    = twm_pkg::TWM_SEQ_FAST;
        top_value   = compare_a_active;
        top_is_cmpa = 1'b1;
      end
      default: begin
        seq_kind = twm_pkg::TWM_SEQ_OTHER;
      end
    endcase
  end

endmodule // twm_mode_dec

// >>> rtl/twm_out_chan.sv
// One compare output channel: output bit register and pin override.
// Assumes match and bottom qualifiers arrive already gated by tick.
`timescale 1ns/1ps
module twm_out_chan (
  // Clock and reset
  input  wire logic        ref_clk,
  input  wire logic        reset_n,
  // Events
  input  wire logic        match_ev,
  input  wire logic        bottom_ev,
  input  wire logic        force_ev,
  input  wire logic        is_fast,
  // Configuration
  input  wire logic [1:0]  compare_output_action,
  // Port pin
  input  wire logic        port_data_bit,
  input  wire logic        output_pin_direction_bit,
  output logic             waveform_output_bit,
  output logic             pin_o,
  output logic             pin_oe
);

  logic wob_r;

  // ----------------------------------------------------------------------
  // Output bit register
  // ----------------------------------------------------------------------
  // Match/force act per action code; fast PWM clear and set also act at bottom
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      wob_r <= 1'b0;
    end else if (compare_output_action == twm_pkg::ACT_NONE) begin
      wob_r <= wob_r;
    end else if (is_fast && bottom_ev &&
                 compare_output_action != twm_pkg::ACT_TOGGLE) begin
      // Toggle has no bottom action, so it keeps its 50% duty
      wob_r <= (compare_output_action == twm_pkg::ACT_CLEAR);
    end else if (match_ev || (force_ev && !is_fast)) begin
      unique case (compare_output_action)
        twm_pkg::ACT_TOGGLE: wob_r <= !wob_r;
        twm_pkg::ACT_CLEAR:  wob_r <= 1'b0;
        twm_pkg::ACT_SET:    wob_r <= 1'b1;
        default:             wob_r <= wob_r;
      endcase
    end
  end

  // Pin override; direction bit still owns the enable
  assign waveform_output_bit = wob_r;
  assign pin_o  = (compare_output_action != twm_pkg::ACT_NONE) ?
                  wob_r : port_data_bit;
  assign pin_oe = output_pin_direction_bit;

endmodule // twm_out_chan

// >>> rtl/twm_timer16.sv
// Top of the 16-bit timer waveform block: counter, compares, flags, pins.
// Assumes timer_tick is a one-cycle enable from an external prescaler and
// that software strobes come from logic on ref_clk.
//
// Functional notes
// - Nonzero action overrides port data with output bit; direction still enables.
// - Reset clears each output bit register.
// - Action zero leaves the output bit unchanged on matches.
// - New action applies at next match; force strobe acts now outside PWM.
// - Action setting never touches capture unit behaviour.
// - Normal mode counts up, never clears, wraps FFFF to 0000.
// - Normal mode sets overflow when counter becomes zero; hardware never clears.
// - Counter writes accepted any time in normal mode.
// - Clear-on-match clears at compare A (4) or capture (12) top.
// - Top writes immediate in clear-on-match; below count means wrap first.
// - Clear-on-match sets the flag of the top register at top.
// - Clear-on-match with action 1 toggles output A each match.
// - Clear-on-match sets overflow only on MAX to zero pass.
// - Modes 5,6,7,14,15 run single-slope fast PWM.
// - Fast PWM tops fixed, capture or compare A; clear next tick.
// - Non-inverting clears on match, sets at zero; inverting opposite.
// - Fast PWM sets overflow at top, plus top register flag.
// - Fast PWM sets channel flag when count equals its compare, except on the tick after a counter write.
// - Fixed-top modes mask compare bits above resolution on write.
// - Capture top in fast PWM updates immediately; below count wraps.
// - PWM compare A writes buffered, loaded at top with counter clear.
// - Fast PWM action two non-inverted, three inverted.
// - Normal and clear-on-match write compare directly.
`timescale 1ns/1ps
module twm_timer16 #(
  parameter int CHANNELS = 2
) (
  // Clock and reset
  input  wire logic                         ref_clk,
  input  wire logic                         reset_n,
  // Prescaled timer enable
  input  wire logic                         timer_tick,
  // Mode and actions (channel 0 is A)
  input  wire logic [3:0]                   waveform_mode_select,
  input  wire logic [CHANNELS-1:0][1:0]     compare_output_action,
  input  wire logic [CHANNELS-1:0]          force_compare_strobe,
  // Counter write
  input  wire logic                         counter_wr,
  input  wire logic [15:0]                  counter_wdata,
  // Compare writes
  input  wire logic [CHANNELS-1:0]          compare_wr,
  input  wire logic [CHANNELS-1:0][15:0]    compare_wdata,
  // Capture register, from capture unit
  input  wire logic [15:0]                  capture_value,
  // Flag clears from software
  input  wire logic                         overflow_clr,
  input  wire logic [CHANNELS-1:0]          compare_flag_clr,
  input  wire logic                         capture_flag_clr,
  // Port pins
  input  wire logic [CHANNELS-1:0]          port_data_bit,
  input  wire logic [CHANNELS-1:0]          output_pin_direction_bit,
  output logic      [CHANNELS-1:0]          pin_o,
  output logic      [CHANNELS-1:0]          pin_oe,
  // Status
  output logic      [15:0]                  counter_value,
  output logic      [CHANNELS-1:0][15:0]    channel_compare_value,
  output logic      [CHANNELS-1:0]          waveform_output_bit,
  output logic                              overflow_flag,
  output logic      [CHANNELS-1:0]          compare_flag,
  output logic                              capture_flag
);

  // ----------------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------------
  twm_pkg::twm_seq_e               seq_kind;
  logic [15:0]                     top_value;
  logic                            top_is_cmpa;
  logic                            top_is_capt;
  logic [15:0]                     fixed_mask;
  logic [15:0]                     cnt_r;
  logic                            block_r;
  logic [CHANNELS-1:0][15:0]       cmp_act_r;
  logic [CHANNELS-1:0][15:0]       cmp_buf_r;
  logic [CHANNELS-1:0]             cmp_pend_r;
  logic [CHANNELS-1:0]             match;
  logic                            at_top;
  logic                            at_max;
  logic                            is_fast;
  logic                            is_pwm;
  logic                            top_hit;
  logic                            wrap_ev;
  logic                            bottom_ev;
  logic                            ovf_r;
  logic [CHANNELS-1:0]             cf_r;
  logic                            capf_r;

  // Equality helper, used by the top and channel comparators
  function automatic logic eq16(input logic [15:0] a, input logic [15:0] b);
    eq16 = (a == b);
  endfunction

  // ----------------------------------------------------------------------
  // Mode decode
  // ----------------------------------------------------------------------
  twm_mode_dec u_dec (
    .waveform_mode_select (waveform_mode_select),
    .compare_a_active     (cmp_act_r[0]),
    .capture_value        (capture_value),
    .seq_kind             (seq_kind),
    .top_value            (top_value),
    .top_is_cmpa          (top_is_cmpa),
    .top_is_capt          (top_is_capt),
    .fixed_mask           (fixed_mask)
  );

  assign is_fast = (seq_kind == twm_pkg::TWM_SEQ_FAST);
  assign is_pwm  = is_fast || (seq_kind == twm_pkg::TWM_SEQ_OTHER);
  // Exact equality only: a top below the count is missed and wraps
  assign at_top  = eq16(cnt_r, top_value) && !block_r;
  assign at_max  = eq16(cnt_r, twm_pkg::CNT_MAX);
  // Counter clears at top in CLEAR_ON_MATCH_MODE and fast PWM
  assign top_hit = timer_tick && at_top &&
                   (seq_kind == twm_pkg::TWM_SEQ_CTC || is_fast);
  // MAX to zero pass in free-running modes (or missed top)
  assign wrap_ev = timer_tick && at_max && !top_hit &&
                   (seq_kind != twm_pkg::TWM_SEQ_OTHER);
  // Fast PWM bottom: output set/clear happens on the clearing tick
  assign bottom_ev = top_hit && is_fast;

  // ----------------------------------------------------------------------
  // Counter
  // ----------------------------------------------------------------------
  // Software write wins; otherwise step on each tick
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      cnt_r <= twm_pkg::CNT_BOTTOM;
    end else if (counter_wr) begin
      cnt_r <= counter_wdata;
    end else if (timer_tick) begin
      unique case (seq_kind)
        twm_pkg::TWM_SEQ_NORMAL: cnt_r <= cnt_r + 16'h0001;
        twm_pkg::TWM_SEQ_CTC,
        twm_pkg::TWM_SEQ_FAST: begin
          cnt_r <= top_hit ? twm_pkg::CNT_BOTTOM : cnt_r + 16'h0001;
        end
        default: cnt_r <= cnt_r; // dual-slope modes live elsewhere
      endcase
    end
  end

  // A counter write blocks matches for the next timer tick
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      block_r <= 1'b0;
    end else if (counter_wr) begin
      block_r <= 1'b1;
    end else if (timer_tick) begin
      block_r <= 1'b0;
    end
  end

  // ----------------------------------------------------------------------
  // Compare registers, buffers and match per channel
  // ----------------------------------------------------------------------
  generate
    for (genvar ch = 0; ch < CHANNELS; ch++) begin : g_cmp
      // Masked write value; fixed tops drop unused high bits
      logic [15:0] wval;
      assign wval = compare_wdata[ch] & fixed_mask;

      // Buffer holds PWM writes until the next top
      always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
          cmp_buf_r[ch]  <= twm_pkg::CNT_BOTTOM;
          cmp_pend_r[ch] <= 1'b0;
        end else if (compare_wr[ch]) begin
          cmp_buf_r[ch]  <= wval;
          cmp_pend_r[ch] <= is_pwm;
        end else if (top_hit) begin
          cmp_pend_r[ch] <= 1'b0;
        end
      end

      // Active register: direct write outside PWM, load at top in PWM
      always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
          cmp_act_r[ch] <= twm_pkg::CNT_BOTTOM;
        end else if (compare_wr[ch] && !is_pwm) begin
          cmp_act_r[ch] <= wval;
        end else if (top_hit && cmp_pend_r[ch]) begin
          cmp_act_r[ch] <= cmp_buf_r[ch];
        end
      end

      assign match[ch] = timer_tick && !block_r &&
                         eq16(cnt_r, cmp_act_r[ch]);

      // Channel output bit and port override
      twm_out_chan u_chan (
        .ref_clk                  (ref_clk),
        .reset_n                  (reset_n),
        .match_ev                 (match[ch]),
        .bottom_ev                (bottom_ev),
        // Force acts only outside every PWM mode, dual-slope included
        .force_ev                 (force_compare_strobe[ch] && !is_pwm),
        .is_fast                  (is_fast),
        .compare_output_action    (compare_output_action[ch]),
        .port_data_bit            (port_data_bit[ch]),
        .output_pin_direction_bit (output_pin_direction_bit[ch]),
        .waveform_output_bit      (waveform_output_bit[ch]),
        .pin_o                    (pin_o[ch]),
        .pin_oe                   (pin_oe[ch])
      );

      // Compare flag: set on match, set beats clear
      always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
          cf_r[ch] <= 1'b0;
        end else if (match[ch] ||
                     (ch == 0 && top_hit && top_is_cmpa)) begin
          cf_r[ch] <= 1'b1;
        end else if (compare_flag_clr[ch]) begin
          cf_r[ch] <= 1'b0;
        end
      end
    end
  endgenerate

  // ----------------------------------------------------------------------
  // Overflow and capture flags
  // ----------------------------------------------------------------------
  // Overflow: fast PWM at top, else on MAX to zero pass
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      ovf_r <= 1'b0;
    end else if (bottom_ev || wrap_ev) begin
      ovf_r <= 1'b1;
    end else if (overflow_clr) begin
      ovf_r <= 1'b0;
    end
  end

  // Capture flag here only marks top; capture events use their own flag
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      capf_r <= 1'b0;
    end else if (top_hit && top_is_capt) begin
      capf_r <= 1'b1;
    end else if (capture_flag_clr) begin
      capf_r <= 1'b0;
    end
  end

  // ----------------------------------------------------------------------
  // Status outputs
  // ----------------------------------------------------------------------
  assign counter_value         = cnt_r;
  assign channel_compare_value = cmp_act_r;
  assign overflow_flag         = ovf_r;
  assign compare_flag          = cf_r;
  assign capture_flag          = capf_r;

  // ----------------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------------
  sequence s_normal_wrap;
    timer_tick && !counter_wr && seq_kind == twm_pkg::TWM_SEQ_NORMAL &&
    cnt_r == twm_pkg::CNT_MAX;
  endsequence

  sequence s_fast_top;
    timer_tick && !counter_wr && is_fast && at_top;
  endsequence

  property p_normal_wrap;
    @(posedge ref_clk) disable iff (!reset_n)
    s_normal_wrap |=> (cnt_r == twm_pkg::CNT_BOTTOM) && ovf_r;
  endproperty
  a_normal_wrap: assert property (p_normal_wrap)
    else $error("normal mode did not wrap with overflow");

  property p_fast_clear;
    @(posedge ref_clk) disable iff (!reset_n)
    s_fast_top |=> cnt_r == twm_pkg::CNT_BOTTOM && ovf_r;
  endproperty
  a_fast_clear: assert property (p_fast_clear)
    else $error("fast PWM top did not clear and flag");

  property p_no_tick_hold;
    @(posedge ref_clk) disable iff (!reset_n)
    !timer_tick && !counter_wr |=> $stable(cnt_r);
  endproperty
  a_no_tick_hold: assert property (p_no_tick_hold)
    else $error("counter moved without timer tick");

  property p_ctc_top_flag;
    @(posedge ref_clk) disable iff (!reset_n)
    top_hit && top_is_capt && seq_kind == twm_pkg::TWM_SEQ_CTC
      |=> capf_r && cnt_r == twm_pkg::CNT_BOTTOM;
  endproperty
  a_ctc_top_flag: assert property (p_ctc_top_flag)
    else $error("capture top flag missing in clear-on-match");

  property p_override;
    @(posedge ref_clk) disable iff (!reset_n)
    compare_output_action[0] != twm_pkg::ACT_NONE
      |-> pin_o[0] == waveform_output_bit[0];
  endproperty
  a_override: assert property (p_override)
    else $error("pin not overridden by output bit");

  property p_act_none;
    @(posedge ref_clk) disable iff (!reset_n)
    compare_output_action[0] == twm_pkg::ACT_NONE
      |=> $stable(waveform_output_bit[0]);
  endproperty
  a_act_none: assert property (p_act_none)
    else $error("output bit moved with action zero");

  property p_ctc_toggle;
    @(posedge ref_clk) disable iff (!reset_n)
    seq_kind == twm_pkg::TWM_SEQ_CTC && match[0] &&
      compare_output_action[0] == twm_pkg::ACT_TOGGLE
      |=> waveform_output_bit[0] != $past(waveform_output_bit[0]);
  endproperty
  a_ctc_toggle: assert property (p_ctc_toggle)
    else $error("output A did not toggle on match");

  property p_fast_bottom_set;
    @(posedge ref_clk) disable iff (!reset_n)
    bottom_ev && compare_output_action[0] == twm_pkg::ACT_CLEAR
      |=> waveform_output_bit[0];
  endproperty
  a_fast_bottom_set: assert property (p_fast_bottom_set)
    else $error("non-inverting output not set at bottom");

  property p_buf_load;
    @(posedge ref_clk) disable iff (!reset_n)
    is_pwm && compare_wr[0] && !top_hit
      |=> $stable(cmp_act_r[0]);
  endproperty
  a_buf_load: assert property (p_buf_load)
    else $error("PWM compare write bypassed the buffer");

endmodule // twm_timer16

// >>> testbench/twm_pin_load.sv
// Load on the waveform pins: the external circuit with pull-down resistors.
// Assumes each pin is driven only while its output enable is high.
`timescale 1ns/1ps
module twm_pin_load #(
  parameter int CHANNELS = 2
) (
  // Pins from the block
  input  wire logic [CHANNELS-1:0] pin_o,
  input  wire logic [CHANNELS-1:0] pin_oe,
  // Level seen by the load
  output logic      [CHANNELS-1:0] pin_level
);
  // ------------------------------------------------------------------
  // Wire resolution
  // ------------------------------------------------------------------
  // Released pin sinks to the pull-down, never keeps a stale value
  always_comb begin
    for (int i = 0; i < CHANNELS; i++) begin
      pin_level[i] = pin_oe[i] ? pin_o[i] : 1'h0;
    end
  end
endmodule // twm_pin_load

// >>> testbench/twm_timer16_tb.sv
// Directed bench for the timer waveform block and its pin load.
// Assumes the package, design files and load model are compiled first.
`timescale 1ns/1ps
module twm_timer16_tb;
  // ------------------------------------------------------------------
  // Signals
  // ------------------------------------------------------------------
  logic             ref_clk = 0, reset_n = 0, tick = 0, cnt_wr = 0;
  logic             ov_clr = 0, cap_clr = 0, ovf, capf;
  logic [3:0]       mode = 0;
  logic [1:0][1:0]  act = 0;
  logic [1:0]       frc = 0, cmp_wr = 0, cf_clr = 0, pdat = 0, pdir = 0;
  logic [1:0]       pin_o, pin_oe, wob, cflag, pin_lvl;
  logic [15:0]      cnt_wd = 0, cap = 0, cnt;
  logic [1:0][15:0] cmp_wd = 0, cmpv;
  logic [15:0]      tops[4] = '{16'h00FF, 16'h01FF, 16'h03FF, 16'h0005};
  logic [3:0]       modes[4] = '{4'h5, 4'h6, 4'h7, 4'hE};
  int               n_fail = 0, total_checks = 0, cyc = 0;

  twm_timer16 #(.CHANNELS(2)) dut (
    .ref_clk(ref_clk), .reset_n(reset_n), .timer_tick(tick),
    .waveform_mode_select(mode), .compare_output_action(act),
    .force_compare_strobe(frc), .counter_wr(cnt_wr),
    .counter_wdata(cnt_wd), .compare_wr(cmp_wr), .compare_wdata(cmp_wd),
    .capture_value(cap), .overflow_clr(ov_clr), .compare_flag_clr(cf_clr),
    .capture_flag_clr(cap_clr), .port_data_bit(pdat),
    .output_pin_direction_bit(pdir), .pin_o(pin_o), .pin_oe(pin_oe),
    .counter_value(cnt), .channel_compare_value(cmpv),
    .waveform_output_bit(wob), .overflow_flag(ovf),
    .compare_flag(cflag), .capture_flag(capf));

  twm_pin_load #(.CHANNELS(2)) load (
    .pin_o(pin_o), .pin_oe(pin_oe), .pin_level(pin_lvl));

  // Clock and hang guard; a hang counts as a mismatch
  initial begin
    forever #25 ref_clk = ~ref_clk;
  end
  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 2000) begin
      n_fail++;
      end_of_test();
    end
  end

  // ------------------------------------------------------------------
  // Tasks
  // ------------------------------------------------------------------
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    total_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("CHECK FAILED %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  // Pulses last one edge, then an idle edge so no strobe is reassigned
  task automatic cyc2();
    @(posedge ref_clk);
    #1 {tick, cnt_wr, cmp_wr, frc, ov_clr, cf_clr, cap_clr} = 0;
    @(posedge ref_clk);
    #1;
  endtask
  task automatic step(input int n);
    repeat (n) begin
      tick = 1;
      cyc2();
    end
  endtask
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  // ------------------------------------------------------------------
  // Test sequence
  // ------------------------------------------------------------------
  initial begin
    repeat (6) @(posedge ref_clk);
    #1 reset_n = 1;
    check(wob, 2'h0);
    pdat = 2'h1; pdir = 2'h1; cyc2();
    check(pin_lvl, 2'h1);
    act = 4'hF; frc = 2'h3; pdat = 2'h0; cyc2();
    check(wob, 2'h3);
    check(pin_lvl, 2'h1);
    act = 4'h0; frc = 2'h3; cyc2();
    check(wob, 2'h3);
    check(pin_oe, 2'h1);
    act = 4'h9; frc = 2'h3; pdat = 2'h1; cyc2();
    check(wob, 2'h0);
    check(pin_lvl, 2'h0);
    // Normal mode wrap; idle edges must not count
    cnt_wd = 16'hFFFE; cnt_wr = 1; cyc2();
    check(cnt, 16'hFFFE);
    step(1);
    check(ovf, 1'h0);
    step(1);
    check(cnt, 16'h0000);
    check(ovf, 1'h1);
    // Clear-on-match at compare A, toggling channel A
    mode = 4'h4; act = 4'h1; cmp_wd[0] = 16'h3; cmp_wr = 2'h1;
    ov_clr = 1; cf_clr = 2'h3; cnt_wd = 0; cnt_wr = 1; cyc2();
    check(cmpv[0], 16'h3);
    step(3);
    check(cnt, 16'h3);
    step(1);
    check(cnt, 16'h0);
    check(cflag, 2'h1);
    check(wob, 2'h1);
    check(ovf, 1'h0);
    cnt_wd = 16'hFFFE; cnt_wr = 1; cyc2();
    step(2);
    check(ovf, 1'h1);
    // Clear-on-match at capture top
    mode = 4'hC; act = 4'hC; cap = 16'h2; frc = 2'h2; cnt_wd = 0; cnt_wr = 1;
    cyc2();
    check(wob, 2'h3);
    step(3);
    check(cnt, 16'h0);
    check(capf, 1'h1);
    // Fast PWM with compare A top; tops kept at or above compares
    mode = 4'h4; cmp_wd = {16'h1, 16'h3}; cmp_wr = 2'h3; cyc2();
    mode = 4'hF; act = 4'hA; ov_clr = 1; cf_clr = 2'h3; cnt_wr = 1; cnt_wd = 0;
    cyc2();
    step(2);
    check(wob, 2'h1);
    check(cflag, 2'h2);
    check(capf, 1'h1);
    step(1);
    cmp_wd[0] = 16'h4; cmp_wr = 2'h1; cyc2();
    check(cmpv[0], 16'h3);
    step(1);
    check(cnt, 16'h0);
    check(ovf, 1'h1);
    check(cflag, 2'h3);
    check(wob, 2'h3);
    check(cmpv[0], 16'h4);
    // Fixed and capture tops, masking of compare writes
    for (int i = 0; i < 4; i++) begin
      mode = modes[i]; cap = 16'h5; cmp_wd[1] = 16'hFFFF; cmp_wr = 2'h2;
      cnt_wd = tops[i] - 16'h1; cnt_wr = 1; cyc2();
      step(2);
      check(cnt, 16'h0);
      check(cmpv[1], (i < 3) ? tops[i] : 16'hFFFF);
    end
    check(capf, 1'h1);
    cap_clr = 1; cyc2();
    check(capf, 1'h0);
    end_of_test();
  end
endmodule // twm_timer16_tb
